// ---- design/isa_wait_state_control.sv ----
// isa wait-state control: config registers and bus cycle stretcher
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
module isa_wait_state_control
  import isa_wait_pkg::*;
#(
  parameter logic [15:0] map_io_base = 16'h0208
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic [ADDR_W-1:0] awaddr_i,
  input  wire logic              awvalid_i,
  output logic                   awready_o,
  input  wire logic [31:0]       wdata_i,
  input  wire logic [3:0]        wstrb_i,
  input  wire logic              wvalid_i,
  output logic                   wready_o,
  output logic [1:0]             bresp_o,
  output logic                   bvalid_o,
  input  wire logic              bready_i,
  input  wire logic [ADDR_W-1:0] araddr_i,
  input  wire logic              arvalid_i,
  output logic                   arready_o,
  output logic [31:0]            rdata_o,
  output logic [1:0]             rresp_o,
  output logic                   rvalid_o,
  input  wire logic              rready_i,
  input  wire logic              cyc_start_i,
  input  wire cyc_req_t          cyc_req_i,
  input  wire logic              memcs16_n_i,
  input  wire cpu_access_t       cpu_access_i,
  output logic                   cyc_ready_o,
  output logic                   bus_cmd_o,
  output logic                   cyc_done_o,
  output logic                   cyc_refused_o,
  output logic                   cpu_fast_o,
  output logic                   page_map_en_o,
  output logic [2:0]             page_miss_waits_o
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_CMD
  } st_t;

  st_t         state_r;
  st_t         state_nxt;
  io_cfg_t     io_cfg_r;
  mem_cfg_t    mem_cfg_r;
  cyc_ctrl_t   cyc_ctrl_r;
  status_t     status;
  logic [11:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_go;
  logic        wr_byte;
  logic [2:0]  mcs_sync_r;
  logic        memcs_n_q;
  logic        floppy_hit;
  logic        disk_hit;
  logic        gen_hit;
  logic        wide_hit;
  logic        refuse;
  logic        accept;
  logic [2:0]  waits;
  logic [1:0]  dly;
  logic [2:0]  waits_r;
  logic        cnt_load;
  logic [2:0]  cnt_val;
  logic        cnt_zero;
  logic        fast_ok;
  logic        conflict;
  logic [2:0]  cmd_len_r;

  function automatic logic mapped(input logic [11:0] a);
    return a == ADDR_IO_WAIT || a == ADDR_MEM_WAIT ||
           a == ADDR_CYC_CTRL || a == ADDR_STATUS;
  endfunction

  // axi4-lite write channel: address and data taken in either order
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      awready_o <= 1'b1;
      wready_o  <= 1'b1;
      bvalid_o  <= 1'b0;
      bresp_o   <= RESP_OKAY;
      aw_addr_r <= '0;
      w_data_r  <= '0;
      w_strb_r  <= '0;
    end
    else
    begin
      if (awvalid_i && awready_o)
      begin
        aw_addr_r <= awaddr_i;
        awready_o <= 1'b0;
      end
      if (wvalid_i && wready_o)
      begin
        w_data_r <= wdata_i;
        w_strb_r <= wstrb_i;
        wready_o <= 1'b0;
      end
      if (wr_go)
      begin
        bvalid_o <= 1'b1;
        bresp_o  <= mapped(aw_addr_r) ? RESP_OKAY : RESP_DECERR;
      end
      else if (bvalid_o && bready_i)
      begin
        bvalid_o  <= 1'b0;
        awready_o <= 1'b1;
        wready_o  <= 1'b1;
      end
    end
  end

  assign wr_go   = !awready_o && !wready_o && !bvalid_o;
  assign wr_byte = wr_go && w_strb_r[0];

  // axi4-lite read channel: answer one cycle after the address
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      arready_o <= 1'b1;
      rvalid_o  <= 1'b0;
      rresp_o   <= RESP_OKAY;
      rdata_o   <= '0;
    end
    else if (arvalid_i && arready_o)
    begin
      arready_o <= 1'b0;
      rvalid_o  <= 1'b1;
      rresp_o   <= mapped(araddr_i) ? RESP_OKAY : RESP_DECERR;
      unique case (araddr_i)
        ADDR_IO_WAIT:  rdata_o <= {24'h0, io_cfg_r};
        ADDR_MEM_WAIT: rdata_o <= {24'h0, mem_cfg_r};
        ADDR_CYC_CTRL: rdata_o <= {24'h0, cyc_ctrl_r};
        ADDR_STATUS:   rdata_o <= {24'h0, status};
        default:       rdata_o <= '0;
      endcase
    end
    else if (rvalid_o && rready_i)
    begin
      rvalid_o  <= 1'b0;
      arready_o <= 1'b1;
    end
  end

  // configuration registers; speed starts low from reset
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      io_cfg_r   <= io_cfg_t'(RST_IO_WAIT);
      mem_cfg_r  <= mem_cfg_t'(RST_MEM_WAIT);
      cyc_ctrl_r <= cyc_ctrl_t'(RST_CYC_CTRL);
    end
    else if (wr_byte)
    begin
      if (aw_addr_r == ADDR_IO_WAIT)
        io_cfg_r <= io_cfg_t'(w_data_r[7:0]);
      if (aw_addr_r == ADDR_MEM_WAIT)
        mem_cfg_r <= mem_cfg_t'(w_data_r[7:0] & MEM_WR_MASK);
      if (aw_addr_r == ADDR_CYC_CTRL)
        cyc_ctrl_r <= cyc_ctrl_t'({5'h0, w_data_r[2:0]});
    end
  end

  // memcs16 pin: a change counts once the last two stages agree
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      mcs_sync_r <= 3'h7;
      memcs_n_q  <= 1'b1;
    end
    else
    begin
      mcs_sync_r <= {mcs_sync_r[1:0], memcs16_n_i};
      if (mcs_sync_r[1] == mcs_sync_r[2])
        memcs_n_q <= mcs_sync_r[2];
    end
  end

  // address classes and wait selection for the offered cycle
  always_comb
  begin
    floppy_hit = cyc_req_i.is_io &&
                 (cyc_req_i.addr & RANGE_MASK) == FLOPPY_BASE;
    disk_hit   = cyc_req_i.is_io &&
                 (cyc_req_i.addr & RANGE_MASK) == DISK_BASE;
    gen_hit    = cyc_req_i.is_io && !floppy_hit && !disk_hit &&
                 cyc_req_i.addr >= GEN_IO_LO &&
                 cyc_req_i.addr <= GEN_IO_HI &&
                 cyc_req_i.addr[15:1] != map_io_base[15:1];
    wide_hit   = !memcs_n_q ||
                 (cyc_req_i.dos_rom_select && cyc_ctrl_r.dos_rom_wide);
    refuse     = !cyc_req_i.is_io && cyc_req_i.is_write &&
                 ((cyc_req_i.dos_rom_select &&
                   !mem_cfg_r.dos_rom_write_enable) ||
                  (cyc_req_i.bios_rom_select &&
                   !mem_cfg_r.bios_rom_write_enable));
    if (floppy_hit)
      waits = WAIT_BASE_FIVE - {1'b0, io_cfg_r.floppy_io_wait_sel};
    else if (disk_hit)
      waits = WAIT_BASE_FIVE - {1'b0, io_cfg_r.disk_io_wait_sel};
    else if (gen_hit)
      waits = WAIT_BASE_FIVE - {1'b0, io_cfg_r.general_io_wait_sel};
    else if (cyc_req_i.is_io)
      waits = MIN_WAITS;
    else if (wide_hit)
      waits = WAIT_BASE_FOUR - {1'b0, mem_cfg_r.wide_mem_wait_sel};
    else
      waits = WAIT_BASE_FIVE - {1'b0, mem_cfg_r.narrow_mem_wait_sel};
    if (!cyc_req_i.is_io)
      dly = CMD_DLY_ONE;
    else if (cyc_ctrl_r.io_command_delay[1])
      dly = CMD_DLY_HALF;
    else if (cyc_ctrl_r.io_command_delay[0])
      dly = CMD_DLY_TWO;
    else
      dly = CMD_DLY_ONE;
  end

  assign accept = cyc_start_i && state_r == ST_IDLE;

  // cycle sequencer: delay, then hold the command for the wait count
  always_comb
  begin
    state_nxt = state_r;
    cnt_load  = 1'b0;
    cnt_val   = '0;
    unique case (state_r)
      ST_IDLE:
        if (accept && !refuse)
        begin
          cnt_load = 1'b1;
          if (dly == CMD_DLY_HALF)
          begin
            state_nxt = ST_CMD;
            cnt_val   = waits - 3'h1;
          end
          else
          begin
            state_nxt = ST_DELAY;
            cnt_val   = {1'b0, dly} - 3'h1;
          end
        end
      ST_DELAY:
        if (cnt_zero)
        begin
          state_nxt = ST_CMD;
          cnt_load  = 1'b1;
          cnt_val   = waits_r - 3'h1;
        end
      ST_CMD:
        if (cnt_zero)
          state_nxt = ST_IDLE;
    endcase
  end

  wait_counter #(
    .W (3)
  ) u_wait_counter (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .load_i  (cnt_load),
    .value_i (cnt_val),
    .zero_o  (cnt_zero)
  );

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      state_r <= ST_IDLE;
    else
      state_r <= state_nxt;
  end

  // cycle outputs and latched wait count
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      waits_r       <= '0;
      cyc_ready_o   <= 1'b0;
      bus_cmd_o     <= 1'b0;
      cyc_done_o    <= 1'b0;
      cyc_refused_o <= 1'b0;
      page_map_en_o <= 1'b0;
    end
    else
    begin
      cyc_ready_o   <= state_nxt == ST_IDLE;
      bus_cmd_o     <= state_nxt == ST_CMD;
      cyc_done_o    <= (state_r == ST_CMD && cnt_zero) ||
                       (accept && refuse);
      cyc_refused_o <= accept && refuse;
      if (accept)
      begin
        waits_r       <= waits;
        page_map_en_o <= !cyc_req_i.dma ||
                         io_cfg_r.dma_page_map_enable;
      end
    end
  end

  // cpu clock rate: fast only when permitted and no isa cycle runs
  assign fast_ok = cpu_access_i == ACC_IDLE ||
                   cpu_access_i == ACC_DRAM ||
                   cpu_access_i == ACC_LOCAL ||
                   cpu_access_i == ACC_FAST_ROM;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      cpu_fast_o        <= 1'b0;
      page_miss_waits_o <= PAGE_MISS_SHORT;
    end
    else
    begin
      cpu_fast_o <= io_cfg_r.speed && fast_ok &&
                    state_nxt == ST_IDLE && !accept;
      page_miss_waits_o <= mem_cfg_r.page_miss_wait_sel ?
                           PAGE_MISS_LONG : PAGE_MISS_SHORT;
    end
  end

  // flags an io wait count that does not exceed the command delay
  always_comb
  begin
    conflict = 1'b0;
    if (cyc_ctrl_r.io_command_delay == 2'h1)
      conflict = io_cfg_r.floppy_io_wait_sel == 2'h3 ||
                 io_cfg_r.disk_io_wait_sel == 2'h3 ||
                 io_cfg_r.general_io_wait_sel == 2'h3;
  end

  always_comb
  begin
    status                = '0;
    status.cpu_fast       = cpu_fast_o;
    status.busy           = state_r != ST_IDLE;
    status.delay_conflict = conflict;
    status.last_waits     = waits_r;
    status.last_refused   = cyc_refused_o;
  end

  // helper: running length of the current command pulse, cleared while the command is low
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !bus_cmd_o)
      cmd_len_r <= '0;
    else
      cmd_len_r <= cmd_len_r + 3'h1;
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_io_two_delay;
    accept && !refuse && cyc_req_i.is_io &&
    cyc_ctrl_r.io_command_delay == 2'h1;
  endsequence

  sequence s_rom_blocked;
    accept && refuse;
  endsequence

  a_cmd_length: assert property (
    $fell(bus_cmd_o) |-> cmd_len_r == waits_r)
    else $error("command length differs from wait count");

  a_cmd_delay: assert property (
    s_io_two_delay |-> ##1 !bus_cmd_o [*2] ##1 bus_cmd_o)
    else $error("two clock command delay not kept");

  a_floppy_wait: assert property (
    accept && !refuse && floppy_hit |=> waits_r ==
    WAIT_BASE_FIVE - {1'b0, $past(io_cfg_r.floppy_io_wait_sel)})
    else $error("floppy wait count wrong");

  a_disk_wait: assert property (
    accept && !refuse && disk_hit |=> waits_r ==
    WAIT_BASE_FIVE - {1'b0, $past(io_cfg_r.disk_io_wait_sel)})
    else $error("disk wait count wrong");

  a_general_wait: assert property (
    accept && gen_hit |=> waits_r ==
    WAIT_BASE_FIVE - {1'b0, $past(io_cfg_r.general_io_wait_sel)})
    else $error("general io wait count wrong");

  a_narrow_wait: assert property (
    accept && !cyc_req_i.is_io && !wide_hit |=> waits_r ==
    WAIT_BASE_FIVE - {1'b0, $past(mem_cfg_r.narrow_mem_wait_sel)})
    else $error("narrow memory wait count wrong");

  a_wide_wait: assert property (
    accept && !cyc_req_i.is_io && !memcs_n_q |=> waits_r ==
    WAIT_BASE_FOUR - {1'b0, $past(mem_cfg_r.wide_mem_wait_sel)})
    else $error("wide memory wait count wrong");

  a_rom_refuse: assert property (
    s_rom_blocked |=> cyc_done_o && cyc_refused_o && !bus_cmd_o)
    else $error("rom write not refused");

  a_dma_map: assert property (
    accept |=> page_map_en_o == (!$past(cyc_req_i.dma) ||
    $past(io_cfg_r.dma_page_map_enable)))
    else $error("dma page mapping wrong");

  a_speed_gate: assert property (
    cpu_fast_o |-> $past(io_cfg_r.speed) && $past(fast_ok))
    else $error("fast clock without permission");

  a_isa_slow: assert property (
    state_r != ST_IDLE |-> !cpu_fast_o)
    else $error("fast clock during isa cycle");

  a_page_miss: assert property (
    mem_cfg_r.page_miss_wait_sel |=>
    page_miss_waits_o == PAGE_MISS_LONG)
    else $error("page miss wait not five");

endmodule

// ---- design/wait_counter.sv ----
// loadable down counter that stops at zero
`timescale 1ns/100ps
module wait_counter #(
  parameter int W = 3
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] value_i,
  output logic              zero_o
);

  logic [W-1:0] cnt_r;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      cnt_r <= '0;
    else if (load_i)
      cnt_r <= value_i;
    else if (cnt_r != '0)
      cnt_r <= cnt_r - W'(1);
  end

  assign zero_o = (cnt_r == '0);

endmodule

// ---- pkg/isa_wait_pkg.sv ----
// constants, field layouts and types for the isa wait-state control block
package isa_wait_pkg;

  localparam int ADDR_W = 12;

  // register indexes; byte address is four times the index
  localparam logic [7:0]  IDX_IO_WAIT   = 8'h61;
  localparam logic [7:0]  IDX_MEM_WAIT  = 8'h62;
  localparam logic [11:0] ADDR_IO_WAIT  = {2'b00, IDX_IO_WAIT, 2'b00};
  localparam logic [11:0] ADDR_MEM_WAIT = {2'b00, IDX_MEM_WAIT, 2'b00};
  localparam logic [11:0] ADDR_CYC_CTRL = 12'h1c0;
  localparam logic [11:0] ADDR_STATUS   = 12'h1c4;

  localparam logic [7:0] RST_IO_WAIT  = 8'h00;
  localparam logic [7:0] RST_MEM_WAIT = 8'h00;
  localparam logic [7:0] RST_CYC_CTRL = 8'h00;
  localparam logic [7:0] MEM_WR_MASK  = 8'h7f;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  // wait counts in system clock cycles
  localparam logic [2:0] WAIT_BASE_FIVE  = 3'h5;
  localparam logic [2:0] WAIT_BASE_FOUR  = 3'h4;
  localparam logic [2:0] MIN_WAITS       = 3'h1;
  localparam logic [2:0] PAGE_MISS_SHORT = 3'h3;
  localparam logic [2:0] PAGE_MISS_LONG  = 3'h5;

  // command delay in whole clocks; the half clock rounds down to none
  localparam logic [1:0] CMD_DLY_HALF = 2'h0;
  localparam logic [1:0] CMD_DLY_ONE  = 2'h1;
  localparam logic [1:0] CMD_DLY_TWO  = 2'h2;

  localparam logic [15:0] FLOPPY_BASE = 16'h03f0;
  localparam logic [15:0] DISK_BASE   = 16'h01f0;
  localparam logic [15:0] RANGE_MASK  = 16'hfff8;
  localparam logic [15:0] GEN_IO_LO   = 16'h0100;
  localparam logic [15:0] GEN_IO_HI   = 16'h03ff;

  typedef struct packed {
    logic       dma_page_map_enable;
    logic       speed;
    logic [1:0] general_io_wait_sel;
    logic [1:0] disk_io_wait_sel;
    logic [1:0] floppy_io_wait_sel;
  } io_cfg_t;

  typedef struct packed {
    logic       rsvd;
    logic       dos_rom_write_enable;
    logic       bios_rom_write_enable;
    logic       page_miss_wait_sel;
    logic [1:0] wide_mem_wait_sel;
    logic [1:0] narrow_mem_wait_sel;
  } mem_cfg_t;

  typedef struct packed {
    logic [4:0] rsvd;
    logic       dos_rom_wide;
    logic [1:0] io_command_delay;
  } cyc_ctrl_t;

  typedef struct packed {
    logic       last_refused;
    logic [2:0] last_waits;
    logic       rsvd;
    logic       delay_conflict;
    logic       busy;
    logic       cpu_fast;
  } status_t;

  typedef struct packed {
    logic        is_io;
    logic        is_write;
    logic        dma;
    logic        dos_rom_select;
    logic        bios_rom_select;
    logic [15:0] addr;
  } cyc_req_t;

  typedef enum logic [2:0] {
    ACC_IDLE,
    ACC_DRAM,
    ACC_LOCAL,
    ACC_FAST_ROM,
    ACC_ISA,
    ACC_OTHER
  } cpu_access_t;

endpackage

// ---- tb/isa_bus_peer.sv ----
// far side bus peer: drives the wide-memory select and times bus commands
`timescale 1ns/100ps
module isa_bus_peer (
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       bus_cmd_i,
  input  wire logic       wide_i,
  output logic            memcs16_n_o,
  output logic [7:0]      cmd_len_o
);
  logic prev_r;

  // select is active low; the idle line sits at its pulled-up high level
  assign memcs16_n_o = ~wide_i;

  // length of the latest command pulse, counted in system clocks
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      prev_r    <= 1'b0;
      cmd_len_o <= 8'h00;
    end
    else
    begin
      prev_r <= bus_cmd_i;
      if (bus_cmd_i && !prev_r)
        cmd_len_o <= 8'h01;
      else if (bus_cmd_i)
        cmd_len_o <= cmd_len_o + 8'h01;
    end
  end
endmodule

// ---- tb/test_isa_wait_state_control.sv ----
// self-checking bench for the isa wait-state control block
`timescale 1ns/100ps
module test_isa_wait_state_control;
  import isa_wait_pkg::*;
  localparam logic [15:0] MAP_BASE = 16'h0208;
  logic              clk_i;
  logic              rst_n_i;
  logic [ADDR_W-1:0] awaddr_i;
  logic              awvalid_i;
  logic              awready_o;
  logic [31:0]       wdata_i;
  logic [3:0]        wstrb_i;
  logic              wvalid_i;
  logic              wready_o;
  logic [1:0]        bresp_o;
  logic              bvalid_o;
  logic              bready_i;
  logic [ADDR_W-1:0] araddr_i;
  logic              arvalid_i;
  logic              arready_o;
  logic [31:0]       rdata_o;
  logic [1:0]        rresp_o;
  logic              rvalid_o;
  logic              rready_i;
  logic              cyc_start_i;
  cyc_req_t          cyc_req_i;
  logic              memcs16_n;
  cpu_access_t       cpu_access_i;
  logic              cyc_ready_o;
  logic              bus_cmd_o;
  logic              cyc_done_o;
  logic              cyc_refused_o;
  logic              cpu_fast_o;
  logic              page_map_en_o;
  logic [2:0]        page_miss_waits_o;
  logic              wide;
  logic [7:0]        cmd_len;
  int                fails;
  int                n_checks;

  isa_wait_state_control #(.map_io_base(MAP_BASE)) dut_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i),
    .awaddr_i(awaddr_i), .awvalid_i(awvalid_i), .awready_o(awready_o),
    .wdata_i(wdata_i), .wstrb_i(wstrb_i), .wvalid_i(wvalid_i),
    .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o),
    .bready_i(bready_i), .araddr_i(araddr_i), .arvalid_i(arvalid_i),
    .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o),
    .rvalid_o(rvalid_o), .rready_i(rready_i),
    .cyc_start_i(cyc_start_i), .cyc_req_i(cyc_req_i),
    .memcs16_n_i(memcs16_n), .cpu_access_i(cpu_access_i),
    .cyc_ready_o(cyc_ready_o), .bus_cmd_o(bus_cmd_o),
    .cyc_done_o(cyc_done_o), .cyc_refused_o(cyc_refused_o),
    .cpu_fast_o(cpu_fast_o), .page_map_en_o(page_map_en_o),
    .page_miss_waits_o(page_miss_waits_o)
  );

  isa_bus_peer peer_u (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .bus_cmd_i(bus_cmd_o),
    .wide_i(wide), .memcs16_n_o(memcs16_n), .cmd_len_o(cmd_len)
  );

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      fails++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // handshakes are judged at the falling edge, acted on at the next rise
  task automatic axi_wr(input logic [11:0] a, input logic [7:0] d,
                        input logic [1:0] er);
    logic ta, tw, tb;
    logic [1:0] r;
    awaddr_i <= a;
    wdata_i <= {24'h0, d};
    awvalid_i <= 1'b1;
    wvalid_i <= 1'b1;
    bready_i <= 1'b1;
    tb = 1'b0;
    while (!tb)
    begin
      @(negedge clk_i);
      ta = awvalid_i & awready_o;
      tw = wvalid_i & wready_o;
      tb = bvalid_o & bready_i;
      r = bresp_o;
      @(posedge clk_i);
      if (ta) awvalid_i <= 1'b0;
      if (tw) wvalid_i <= 1'b0;
    end
    chk(r, er);
  endtask

  task automatic axi_rd(input logic [11:0] a, input logic [7:0] ed,
                        input logic [1:0] er);
    logic ta, tr;
    logic [31:0] d;
    logic [1:0] r;
    araddr_i <= a;
    arvalid_i <= 1'b1;
    rready_i <= 1'b1;
    tr = 1'b0;
    while (!tr)
    begin
      @(negedge clk_i);
      ta = arvalid_i & arready_o;
      tr = rvalid_o & rready_i;
      d = rdata_o;
      r = rresp_o;
      @(posedge clk_i);
      if (ta) arvalid_i <= 1'b0;
    end
    chk(d, {24'h0, ed});
    chk(r, er);
  endtask

  // one bus cycle: total length, refusal and command width are checked
  task automatic cyc(input logic [20:0] rq, input int d, input int w,
                     input logic rf);
    logic tk;
    int n;
    cyc_start_i <= 1'b1;
    cyc_req_i <= cyc_req_t'(rq);
    tk = 1'b0;
    n = 0;
    while (!tk && n < 40)
    begin
      @(negedge clk_i);
      tk = cyc_ready_o;
      n++;
      @(posedge clk_i);
    end
    cyc_start_i <= 1'b0;
    chk(tk, 1'b1);
    n = 0;
    do
    begin
      @(negedge clk_i);
      n++;
    end
    while (cyc_done_o !== 1'b1 && n < 40);
    chk(n, rf ? 1 : d + w + 1);
    chk(cyc_refused_o, rf);
    if (!rf) chk(cmd_len, w);
    @(posedge clk_i);
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial
  begin
    #500000;
    fails++;
    wrap_up();
  end

  initial
  begin
    int d;
    int md, hd, gd;
    rst_n_i = 1'b0; awaddr_i = '0; awvalid_i = 1'b0; wdata_i = '0;
    wstrb_i = 4'hf; wvalid_i = 1'b0; bready_i = 1'b0; araddr_i = '0;
    arvalid_i = 1'b0; rready_i = 1'b0; cyc_start_i = 1'b0;
    cyc_req_i = '0; cpu_access_i = ACC_IDLE; wide = 1'b0;
    fails = 0;
    n_checks = 0;
    wt(2);
    rst_n_i <= 1'b1;
    wt(2);
    @(negedge clk_i);
    chk(cpu_fast_o, 1'b0);
    chk(page_miss_waits_o, PAGE_MISS_SHORT);
    @(posedge clk_i);
    axi_rd(ADDR_IO_WAIT, RST_IO_WAIT, RESP_OKAY);
    axi_rd(ADDR_MEM_WAIT, RST_MEM_WAIT, RESP_OKAY);
    axi_rd(12'h100, 8'h00, RESP_DECERR);
    axi_wr(12'h104, 8'h55, RESP_DECERR);
    axi_wr(ADDR_MEM_WAIT, 8'hff, RESP_OKAY);
    axi_rd(ADDR_MEM_WAIT, MEM_WR_MASK, RESP_OKAY);
    @(negedge clk_i);
    chk(page_miss_waits_o, PAGE_MISS_LONG);
    @(posedge clk_i);
    $display("test registers done");
    for (int dl = 0; dl < 3; dl++)
      for (int f = 0; f < 4; f++)
      begin
        // waits stay above the command delay
        if (dl == 1 && f == 3) continue;
        d = (dl == 0) ? 1 : ((dl == 1) ? 2 : 0);
        // distinct fields per range so a swapped field shows up
        md = (dl == 1) ? 3 : 4;
        hd = (f + 1) % md;
        gd = (f + 2) % md;
        axi_wr(ADDR_CYC_CTRL, 8'(dl), RESP_OKAY);
        axi_wr(ADDR_IO_WAIT, {2'b00, 2'(gd), 2'(hd), 2'(f)}, RESP_OKAY);
        cyc({5'b10000, FLOPPY_BASE | 16'h0004}, d, 5 - f, 1'b0);
        cyc({5'b10000, DISK_BASE | 16'h0007}, d, 5 - hd, 1'b0);
        cyc({5'b10000, 16'h03f8}, d, 5 - gd, 1'b0);
        cyc({5'b10000, 16'h01ef}, d, 5 - gd, 1'b0);
      end
    axi_wr(ADDR_CYC_CTRL, 8'h00, RESP_OKAY);
    cyc({5'b10000, MAP_BASE}, 1, 1, 1'b0);
    axi_rd(ADDR_STATUS, 8'h10, RESP_OKAY);
    $display("test io_waits done");
    for (int f = 0; f < 4; f++)
    begin
      axi_wr(ADDR_MEM_WAIT, {4'h0, 2'(3 - f), 2'(f)}, RESP_OKAY);
      cyc({5'b00000, 16'h8000}, 1, 5 - f, 1'b0);
      cyc({5'b00001, 16'h8000}, 1, 5 - f, 1'b0);
      wide <= 1'b1;
      wt(5);
      cyc({5'b00000, 16'h8000}, 1, 1 + f, 1'b0);
      wide <= 1'b0;
      wt(5);
      axi_wr(ADDR_CYC_CTRL, 8'h04, RESP_OKAY);
      cyc({5'b00010, 16'h8000}, 1, 1 + f, 1'b0);
      axi_wr(ADDR_CYC_CTRL, 8'h00, RESP_OKAY);
    end
    $display("test mem_waits done");
    axi_wr(ADDR_MEM_WAIT, 8'h00, RESP_OKAY);
    cyc({5'b01010, 16'h8000}, 1, 5, 1'b1);
    cyc({5'b01001, 16'h8000}, 1, 5, 1'b1);
    axi_wr(ADDR_MEM_WAIT, 8'h60, RESP_OKAY);
    cyc({5'b01010, 16'h8000}, 1, 5, 1'b0);
    cyc({5'b01001, 16'h8000}, 1, 5, 1'b0);
    $display("test rom_writes done");
    for (int m = 0; m < 2; m++)
    begin
      axi_wr(ADDR_IO_WAIT, {m[0], 7'h00}, RESP_OKAY);
      cyc({5'b00100, 16'h8000}, 1, 5, 1'b0);
      @(negedge clk_i);
      chk(page_map_en_o, m[0]);
      @(posedge clk_i);
    end
    axi_wr(ADDR_IO_WAIT, 8'h00, RESP_OKAY);
    cyc({5'b00000, 16'h8000}, 1, 5, 1'b0);
    @(negedge clk_i);
    chk(page_map_en_o, 1'b1);
    @(posedge clk_i);
    $display("test dma_map done");
    for (int s = 0; s < 2; s++)
    begin
      axi_wr(ADDR_IO_WAIT, {1'b0, s[0], 6'h00}, RESP_OKAY);
      for (int a = 0; a < 6; a++)
      begin
        cpu_access_i <= cpu_access_t'(a);
        wt(3);
        @(negedge clk_i);
        chk(cpu_fast_o, s == 1 && a < 4);
        @(posedge clk_i);
      end
      cpu_access_i <= ACC_IDLE;
      cyc({5'b10000, 16'h0300}, 1, 5, 1'b0);
      @(negedge clk_i);
      chk(cpu_fast_o, s[0]);
      @(posedge clk_i);
    end
    $display("test cpu_speed done");
    wrap_up();
  end
endmodule
